// File: rtl/aof_top.sv
`default_nettype none
`include "aof_map.svh"
// Contract
// R1: Clamp on, zero shift: plain 14-bit codes
// R2: Clamp on: top bit flags overrange input
// R3: Shift value resets to zero
// R4: Shift added to raw result after conversion
// R5: Clamp on: saturate to 0x3FFF and 0x0000
// R6: Clamp off: codes beyond nominal span allowed
// R7: Clamp off: below twos complement, above binary
// R8: Clamp off, top bit set: side bit
// R9: Top bit clear: in-range straight binary
// R10: Host writes shift within -1310 and +1310
// R11: Host writes 12-bit value, top three zero
// R12: Shift kept until reset; rewritable between conversions
// R13: Data lines driven only while select and read low
// R14: Falling trigger starts 300 ns conversion
// R15: Sign-extended shift, wide adder, no wrap
module aof_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    sample_trigger_n,
  input  wire logic                    clamp_select,
  input  wire logic                    chip_select_n,
  input  wire logic                    read_strobe_n,
  input  wire logic                    write_strobe_n,
  input  wire logic [`AOF_WORD_W-1:0]  data_in,
  input  wire logic signed [15:0]      sar_raw,
  output logic                         sample_hold,
  output logic                         busy_n,
  output logic [`AOF_WORD_W-1:0]       data_out,
  output logic                         data_oe
);
  // ****************************************
  // State
  // ****************************************
  aof_pkg::aof_top_st_t   st;
  aof_pkg::aof_top_st_t   next_st;
  logic                   buf_in_ready;
  logic                   buf_out_valid;
  logic                   buf_out_ready;
  aof_pkg::aof_word_t     buf_out_data;
  aof_pkg::aof_word_t     formatted;
  logic                   reading;
  logic                   trigger_fall;
  logic signed [`AOF_SUM_W-1:0] shift_ext;
  logic signed [`AOF_SUM_W-1:0] raw_ext;
  logic signed [`AOF_SUM_W-1:0] sum;
  logic                   raw_out;
  logic                   sum_above;
  logic                   sum_below;
  logic                   write_commit;
  logic                   conv_done;
  logic                   push_req;

  // ****************************************
  // Strobe decode
  // ****************************************
  assign reading      = !st.cs_s2 && !st.rd_s2;
  assign trigger_fall = st.conv_d && !st.conv_s2;
  // Buffer drains into the output word only between reads
  assign buf_out_ready = !reading;
  // Shift word taken on strobe release, select still low
  assign write_commit = !st.wr_d && st.wr_s2 && !st.cs_s2; // R12
  // Last timer count ends the conversion
  assign conv_done    = (st.phase == aof_pkg::AOF_CONV) && (st.timer == '0);
  assign push_req     = (st.phase == aof_pkg::AOF_PUSH);

  // ****************************************
  // Result formatting
  // ****************************************
  always_comb begin
    shift_ext = {{(`AOF_SUM_W-`AOF_SHIFT_W){st.shift[`AOF_SHIFT_W-1]}},
                 st.shift[`AOF_SHIFT_W-1:0]}; // R15
    raw_ext   = {sar_raw[15], sar_raw};
    // Wide sum keeps negative and above-span values
    sum       = raw_ext + shift_ext; // R4 R15
    sum_above = (sum > `AOF_CODE_MAX);
    sum_below = (sum < `AOF_CODE_MIN);
    // Flag follows the analog input, not the shifted sum
    raw_out   = (raw_ext < `AOF_CODE_MIN) || (raw_ext > `AOF_CODE_MAX);
    formatted = '0;
    // Clamp mode saturates; open mode passes fifteen bits
    if (st.clamp_s2) begin
      formatted.flag = raw_out; // R2
      if (sum_above) begin
        formatted.code = `AOF_CLAMP_HI; // R5 R1
      end else if (sum_below) begin
        formatted.code = `AOF_CLAMP_LO; // R5 R1
      end else begin
        formatted.code = sum[`AOF_CODE_W-1:0]; // R1
      end
    end else begin
      formatted = sum[`AOF_WORD_W-1:0]; // R6 R7 R8 R9
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st          = st;
    // Pin synchronisers, two stages each
    next_st.conv_s1  = sample_trigger_n;
    next_st.conv_s2  = st.conv_s1;
    next_st.conv_d   = st.conv_s2;

    next_st.clamp_s1 = clamp_select;
    next_st.clamp_s2 = st.clamp_s1;

    next_st.cs_s1    = chip_select_n;
    next_st.cs_s2    = st.cs_s1;
    next_st.rd_s1    = read_strobe_n;
    next_st.rd_s2    = st.rd_s1;
    next_st.wr_s1    = write_strobe_n;
    next_st.wr_s2    = st.wr_s1;
    next_st.wr_d     = st.wr_s2;

    next_st.din_s1   = data_in;
    next_st.din_s2   = st.din_s1;

    // Shift word latched on write strobe release
    if (write_commit) begin
      next_st.shift = st.din_s2; // R12
    end

    // Conversion sequencer
    case (st.phase)
      aof_pkg::AOF_IDLE: begin
        // Triggers while busy never reach this branch
        if (trigger_fall) begin
          next_st.phase  = aof_pkg::AOF_CONV; // R14
          next_st.timer  = `AOF_TIMER_W'(`AOF_CONV_CYCLES - 1);
          next_st.busy_n = 1'b0;
          next_st.hold   = 1'b1; // R14
        end
      end
      aof_pkg::AOF_CONV: begin
        if (conv_done) begin
          next_st.result = formatted; // R4
          next_st.phase  = aof_pkg::AOF_PUSH;
        end else begin
          next_st.timer = st.timer - `AOF_TIMER_W'(1); // R14
        end
      end
      aof_pkg::AOF_PUSH: begin
        // Stalls here while the buffer is full
        if (buf_in_ready) begin
          next_st.phase  = aof_pkg::AOF_IDLE;
          next_st.busy_n = 1'b1;
          next_st.hold   = 1'b0;
        end
      end
      default: begin
        next_st.phase = aof_pkg::AOF_IDLE;
      end
    endcase

    // Output word held steady during a read
    if (buf_out_valid && buf_out_ready) begin
      next_st.data_q = buf_out_data;
    end
    // Enable follows the synced select and read strobes
    next_st.data_oe = reading; // R13
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Chains reset to the idle pin levels: no false edge after reset
      st.conv_s1  <= 1'b1;
      st.conv_s2  <= 1'b1;
      st.conv_d   <= 1'b1;
      st.clamp_s1 <= 1'b0;
      st.clamp_s2 <= 1'b0;
      st.cs_s1    <= 1'b1;
      st.cs_s2    <= 1'b1;
      st.rd_s1    <= 1'b1;
      st.rd_s2    <= 1'b1;
      st.wr_s1    <= 1'b1;
      st.wr_s2    <= 1'b1;
      st.wr_d     <= 1'b1;
      st.din_s1   <= '0;
      st.din_s2   <= '0;
      st.shift    <= `AOF_SHIFT_RESET; // R3
      st.phase    <= aof_pkg::AOF_IDLE;
      st.timer    <= '0;
      st.result   <= '0;
      st.data_q   <= '0;
      st.data_oe  <= 1'b0;
      st.busy_n   <= 1'b1;
      st.hold     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Result buffer
  // ****************************************
  aof_skid u_skid (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_req),
    .in_ready  (buf_in_ready),
    .in_data   (st.result),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign sample_hold = st.hold; // R14
  assign busy_n      = st.busy_n;
  assign data_out    = st.data_q;
  assign data_oe     = st.data_oe; // R13
endmodule : aof_top
`default_nettype wire

// File: rtl/aof_map.svh
`ifndef AOF_MAP_SVH
`define AOF_MAP_SVH
// ****************************************
// Widths and fields
// ****************************************
`define AOF_CODE_W       14
`define AOF_WORD_W       15
`define AOF_SUM_W        17
`define AOF_SHIFT_W      12
`define AOF_FLAG_BIT     14
`define AOF_SIDE_BIT     13
// ****************************************
// Codes and reset values
// ****************************************
`define AOF_SHIFT_RESET  15'h0000
`define AOF_CODE_MAX     17'sh03FFF
`define AOF_CODE_MIN     17'sh00000
`define AOF_CLAMP_HI     14'h3FFF
`define AOF_CLAMP_LO     14'h0000
// ****************************************
// Timing
// ****************************************
`define AOF_CLK_MHZ      40
`define AOF_CONV_NS      300
`define AOF_CONV_CYCLES  ((`AOF_CONV_NS * `AOF_CLK_MHZ + 999) / 1000)
`define AOF_TIMER_W      5
`endif

// File: rtl/aof_pkg.sv
`default_nettype none
`include "aof_map.svh"
package aof_pkg;
  typedef enum logic [1:0] {AOF_IDLE, AOF_CONV, AOF_PUSH} aof_phase_t;

  typedef struct packed {
    logic                     flag;
    logic [`AOF_CODE_W-1:0]   code;
  } aof_word_t;

  typedef struct packed {
    aof_word_t [1:0] mem;
    logic            wr_ptr;
    logic            rd_ptr;
    logic [1:0]      count;
  } aof_skid_st_t;

  typedef struct packed {
    logic                      conv_s1;
    logic                      conv_s2;
    logic                      conv_d;
    logic                      clamp_s1;
    logic                      clamp_s2;
    logic                      cs_s1;
    logic                      cs_s2;
    logic                      rd_s1;
    logic                      rd_s2;
    logic                      wr_s1;
    logic                      wr_s2;
    logic                      wr_d;
    logic [`AOF_WORD_W-1:0]    din_s1;
    logic [`AOF_WORD_W-1:0]    din_s2;
    logic [`AOF_WORD_W-1:0]    shift;
    aof_phase_t                phase;
    logic [`AOF_TIMER_W-1:0]   timer;
    aof_word_t                 result;
    aof_word_t                 data_q;
    logic                      data_oe;
    logic                      busy_n;
    logic                      hold;
  } aof_top_st_t;
endpackage : aof_pkg
`default_nettype wire

// File: rtl/aof_skid.sv
`default_nettype none
`include "aof_map.svh"
// ****************************************
// Two-entry result buffer
// ****************************************
module aof_skid (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire aof_pkg::aof_word_t in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output aof_pkg::aof_word_t     out_data
);
  aof_pkg::aof_skid_st_t st;
  aof_pkg::aof_skid_st_t next_st;
  logic                  push;
  logic                  pop;

  assign in_ready  = (st.count != 2'd2);
  assign out_valid = (st.count != 2'd0);
  assign out_data  = st.mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr         = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    if (push && !pop) begin
      next_st.count = st.count + 2'd1;
    end else if (pop && !push) begin
      next_st.count = st.count - 2'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : aof_skid
`default_nettype wire

// File: tb/aof_monitor.sv
`default_nettype none
module aof_monitor (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               sample_trigger_n,
  input wire logic               clamp_select,
  input wire logic               chip_select_n,
  input wire logic               read_strobe_n,
  input wire logic signed [15:0] sar_raw,
  input wire logic               sample_hold,
  input wire logic               busy_n,
  input wire logic [14:0]        data_out,
  input wire logic               data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // *****
  // Checks
  // *****
  wire rd_on = !chip_select_n && !read_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_conv;
    !busy_n [*8] ##1 !busy_n [*5];
  endsequence
  property p_fmt(c, b, m, v);
    $rose(busy_n) && read_strobe_n && $past(read_strobe_n, 3) && $past(clamp_select, 4) == c && b
      |-> ##1 (data_out & m) == v;
  endproperty
  a_oe_gated: assert property (data_oe == $past(rd_on, 3))
    else $error("bad enable");
  a_out_frozen: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("data moved");
  a_conv_start: assert property ($fell(sample_trigger_n) && busy_n |-> ##[3:5] !busy_n)
    else $error("no start");
  a_conv_len: assert property ($fell(busy_n) |-> s_conv)
    else $error("short conversion");
  a_hold_busy: assert property (sample_hold |-> !busy_n)
    else $error("stray hold");
  a_clamp_hi: assert property (p_fmt(1, $past(sar_raw, 2) > 17693, 15'h7FFF, 15'h7FFF))
    else $error("bad high clamp");
  a_clamp_lo: assert property (p_fmt(1, $past(sar_raw, 2) < -1310, 15'h7FFF, 15'h4000))
    else $error("bad low clamp");
  a_side_neg: assert property (p_fmt(0, $past(sar_raw, 2) < -1310, 15'h6000, 15'h6000))
    else $error("bad side");
endmodule : aof_monitor
bind aof_top aof_monitor mon (.clk(clk), .rst(rst), .sample_trigger_n(sample_trigger_n),
  .clamp_select(clamp_select), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .sar_raw(sar_raw), .sample_hold(sample_hold), .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// File: tb/aof_host.sv
`default_nettype none
module aof_host (
  input  wire logic        clk,
  input  wire logic        oe,
  input  wire logic [14:0] dout,
  output var  logic        cs_n,
  output var  logic        rd_n,
  output var  logic        wr_n,
  output var  logic [14:0] din
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    din = 15'h0000;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic put(input logic [11:0] s);
    cs_n = 1'b0;
    din = {3'h0, s};
    step(1);
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(4);
    cs_n = 1'b1;
    din = ~din;
    step(2);
  endtask : put
  task automatic get(output logic [14:0] v);
    cs_n = 1'b0;
    rd_n = 1'b0;
    for (int i = 0; i < 9 && oe !== 1'b1; i++) step(1);
    v = dout;
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(4);
  endtask : get
endmodule : aof_host
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk, rst, trig, clamp;
  logic               hold, busy_n, oe, cs_n, rd_n, wr_n;
  logic        [14:0] dout, din, v;
  logic signed [15:0] raw;
  logic        [11:0] s;
  int                 num_errors = 0, total_checks = 0, cyc = 0, seed = 37, r;
  int                 sv[6] = '{0, -1310, -512, 256, 1310, 1024};
  int                 rv[7] = '{-1400, -1, 0, 1000, 16383, 16384, 17800};
  always #12.5 clk = ~clk;
  aof_top uut (.clk(clk), .rst(rst), .sample_trigger_n(trig), .clamp_select(clamp), .chip_select_n(cs_n),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(oe ? dout : din), .sar_raw(raw),
    .sample_hold(hold), .busy_n(busy_n), .data_out(dout), .data_oe(oe));
  aof_host h (.clk(clk), .oe(oe), .dout(dout), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .din(din));
  function automatic logic [14:0] fmt(input logic signed [15:0] x, input logic [11:0] k, input logic c);
    logic signed [16:0] t;
    t = x + $signed(k);
    if (!c) return t[14:0];
    return {x < 0 || x > 16383, t < 0 ? 14'h0000 : t > 16383 ? 14'h3FFF : t[13:0]};
  endfunction : fmt
  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic conv(input int x, input logic c, input bit w);
    raw = 16'(x);
    clamp = c;
    trig = 1'b0;
    h.step(2);
    trig = 1'b1;
    h.step(4);
    for (int i = 0; w && i < 40 && busy_n !== 1'b1; i++) h.step(1);
    h.step(3);
  endtask : conv
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    trig = 1'b1;
    clamp = 1'b1;
    raw = 16'h0000;
    h.step(16);
    rst = 1'b0;
    h.step(3);
    for (int k = 0; k < 12; k++) begin
      s = k < 6 ? 12'(sv[k]) : 12'(($random(seed) & 16'h7FFF) % 2621 - 1310);
      h.put(s);
      for (int j = 0; j < 9; j++) begin
        r = j < 7 ? rv[j] : ($random(seed) & 16'h7FFF) % 19201 - 1400;
        for (int c = 0; c < 2; c++) begin
          conv(r, c[0], 1'b1);
          h.get(v);
          chk(v, fmt(16'(r), s, c[0]));
        end
      end
    end
    h.put(12'd500);
    rst = 1'b1;
    h.step(2);
    rst = 1'b0;
    h.step(3);
    conv(100, 1'b1, 1'b1);
    h.get(v);
    chk(v, 15'd100);
    // Hold a read so the buffer fills and the third result stalls
    h.cs_n = 1'b0;
    h.rd_n = 1'b0;
    for (int j = 1; j < 4; j++) conv(j * 10, 1'b1, j < 3);
    h.step(30);
    chk(15'(busy_n), 15'h0000);
    chk(15'(hold), 15'h0001);
    chk(dout, 15'd100);
    h.cs_n = 1'b1;
    h.rd_n = 1'b1;
    // Buffered words reach the output one per cycle once the read ends
    h.step(3);
    for (int j = 1; j < 4; j++) begin
      chk(dout, 15'(j * 10));
      h.step(1);
    end
    h.get(v);
    chk(v, 15'd30);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
